//--- design/power_down_pkg.sv
// constants for the processor power-down mode logic
// Functional notes
// - six-bit select field, bits 15 to 10 of control/status word; zero means none.
// - selected mode takes effect within nine clock cycles after the write.
// - code 001001 enters light sleep, woken only by an enabled interrupt.
// - code 010001 enters light sleep, woken by any interrupt.
// - wake by non-enabled interrupt resumes at sleep point, no service routine.
// - wake by enabled interrupt runs service routine, then resumes.
// - service routine runs only when global and nonmaskable enables are set.
// - code 011010 halts pll output, stopping the whole chip.
// - code 011100 stops pll input clock; deepest sleep.
// - both pll-stopping modes end only by device reset.
// - pll-stopping modes keep state and freeze functional outputs.
// - asynchronous or externally clocked peripherals may still toggle outputs.
// - reset after deepest sleep waits for pll relock as at power-up.
// - only reference clock input and third clock output are gated.
// - with pll bypassed both pll-stopping modes have no effect.
package power_down_pkg;
	localparam int          ADDR_W        = 4;
	localparam logic [3:0]  CSR_ADDR      = 4'h0;
	localparam logic [3:0]  PLL_CTRL_ADDR = 4'h4;
	localparam logic [3:0]  IRQ_ADDR      = 4'h8;
	localparam logic [3:0]  STAT_ADDR     = 4'hC;
	localparam int          SEL_LSB       = 10;
	localparam int          SEL_MSB       = 15;
	localparam int          GLOBAL_EN_BIT = 0;
	localparam int          NMI_EN_BIT    = 1;
	localparam int          ENGAGE_BIT    = 0;
	localparam logic [5:0]  SEL_NONE      = 6'h00;
	localparam logic [5:0]  SEL_LIGHT_EN  = 6'h09;
	localparam logic [5:0]  SEL_LIGHT_ANY = 6'h11;
	localparam logic [5:0]  SEL_PLL_OUT   = 6'h1A;
	localparam logic [5:0]  SEL_PLL_IN    = 6'h1C;
	localparam logic [3:0]  ENTRY_DELAY   = 4'h9;
	localparam logic [15:0] RELOCK_CYCLES = 16'h0100;
	localparam logic [31:0] CSR_RESET     = 32'h0000_0000;
	localparam logic [31:0] PLL_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	typedef enum logic [2:0] {
		ST_RUN, ST_ARM, ST_LIGHT, ST_SERVICE, ST_PLL_OUT, ST_PLL_IN, ST_RELOCK
	} state_t;
endpackage

//--- design/power_down_mode_logic.sv
// power-down mode controller with avalon-mm register slave
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module power_down_mode_logic #(
	parameter logic [15:0] RELOCK = power_down_pkg::RELOCK_CYCLES
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        srst,
	// avalon-mm slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// interrupt side
	input  wire logic        irqPending,
	input  wire logic        irqEnabled,
	output logic             serviceRequest,
	output logic             resumeAtSleep,
	// clock gating outputs
	output logic             cpuClockEnable,
	output logic             dmaClockEnable,
	output logic             pllOutputEnable,
	output logic             refClockGate,
	output logic             thirdClockGate,
	output logic             ioFreeze,
	output logic             pllLocked
);
	power_down_pkg::state_t stateQ, stateD;
	logic [31:0] csrQ;
	logic [31:0] pllQ;
	logic [3:0]  delayQ;
	logic [15:0] lockQ;
	logic [5:0]  pendSelQ;
	logic        readAckQ;
	logic [31:0] readdataQ;

	// decode
	wire        csrHit   = (address == power_down_pkg::CSR_ADDR);
	wire        pllHit   = (address == power_down_pkg::PLL_CTRL_ADDR);
	wire        irqHit   = (address == power_down_pkg::IRQ_ADDR);
	wire        statHit  = (address == power_down_pkg::STAT_ADDR);
	// writes stall while a pll-stopping mode is active, as the chip is frozen
	wire        frozen   = (stateQ == power_down_pkg::ST_PLL_OUT) ||
	                       (stateQ == power_down_pkg::ST_PLL_IN);
	wire        wrTake   = write && !frozen;
	wire [5:0]  newSel   = writedata[power_down_pkg::SEL_MSB:power_down_pkg::SEL_LSB];
	wire        selWrite = wrTake && csrHit && byteenable[1];
	wire        engaged  = pllQ[power_down_pkg::ENGAGE_BIT];
	wire        globalEn = csrQ[power_down_pkg::GLOBAL_EN_BIT];
	wire        nmiEn    = csrQ[power_down_pkg::NMI_EN_BIT];

	function automatic logic [31:0] mergeBytes(input logic [31:0] old,
	                                           input logic [31:0] data,
	                                           input logic [3:0]  be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// registers
	always_ff @(posedge clock) begin
		if (srst) begin
			csrQ <= power_down_pkg::CSR_RESET;
			pllQ <= power_down_pkg::PLL_CTRL_RESET;
		end else if (wrTake && csrHit) begin
			csrQ <= mergeBytes(csrQ, writedata, byteenable);
		end else if (wrTake && pllHit) begin
			pllQ <= mergeBytes(pllQ, writedata, byteenable);
		end
	end

	// read path: one wait cycle, answer on the second edge
	wire [31:0] statWord = {25'h000_0000, stateQ, engaged, pllLocked, frozen, 1'b0};
	wire [31:0] readMux  = csrHit  ? csrQ :
	                       pllHit  ? pllQ :
	                       irqHit  ? {30'h0000_0000, irqEnabled, irqPending} :
	                       statHit ? statWord : power_down_pkg::UNMAPPED_READ;
	always_ff @(posedge clock) begin
		if (srst) begin
			readAckQ  <= 1'b0;
			readdataQ <= 32'h0000_0000;
		end else begin
			readAckQ  <= read && !readAckQ;
			readdataQ <= readMux;
		end
	end
	assign readdata    = readdataQ;
	assign waitrequest = (read && !readAckQ) || (write && frozen);

	// state machine
	wire delayDone = (delayQ == 4'h1);
	always_comb begin
		stateD = stateQ;
		case (stateQ)
			power_down_pkg::ST_RUN: begin
				if (selWrite && newSel != power_down_pkg::SEL_NONE) begin
					stateD = power_down_pkg::ST_ARM;
				end
			end
			power_down_pkg::ST_ARM: begin
				if (delayDone) begin
					case (pendSelQ)
						power_down_pkg::SEL_LIGHT_EN,
						power_down_pkg::SEL_LIGHT_ANY: stateD = power_down_pkg::ST_LIGHT;
						power_down_pkg::SEL_PLL_OUT:
							stateD = engaged ? power_down_pkg::ST_PLL_OUT
							                 : power_down_pkg::ST_RUN;
						power_down_pkg::SEL_PLL_IN:
							stateD = engaged ? power_down_pkg::ST_PLL_IN
							                 : power_down_pkg::ST_RUN;
						default: stateD = power_down_pkg::ST_RUN;
					endcase
				end
			end
			power_down_pkg::ST_LIGHT: begin
				if (irqPending && irqEnabled) begin
					stateD = (globalEn && nmiEn) ? power_down_pkg::ST_SERVICE
					                       : power_down_pkg::ST_RUN;
				end else if (irqPending && pendSelQ == power_down_pkg::SEL_LIGHT_ANY) begin
					stateD = power_down_pkg::ST_RUN;
				end
			end
			power_down_pkg::ST_SERVICE: stateD = power_down_pkg::ST_RUN;
			// only srst leaves these two
			power_down_pkg::ST_PLL_OUT: stateD = stateQ;
			power_down_pkg::ST_PLL_IN:  stateD = stateQ;
			power_down_pkg::ST_RELOCK: begin
				if (lockQ == 16'h0000) begin
					stateD = power_down_pkg::ST_RUN;
				end
			end
			default: stateD = power_down_pkg::ST_RUN;
		endcase
	end

	// reset in pll-input stop or relock restarts relock; an unknown state comes up running
	always_ff @(posedge clock) begin
		if (srst) begin
			if (stateQ == power_down_pkg::ST_PLL_IN || stateQ == power_down_pkg::ST_RELOCK) begin
				stateQ <= power_down_pkg::ST_RELOCK;
			end else begin
				stateQ <= power_down_pkg::ST_RUN;
			end
			lockQ  <= RELOCK;
		end else begin
			stateQ <= stateD;
			if (stateQ == power_down_pkg::ST_RELOCK && lockQ != 16'h0000) begin
				lockQ <= lockQ - 16'h0001;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			delayQ   <= 4'h0;
			pendSelQ <= power_down_pkg::SEL_NONE;
		end else if (stateQ == power_down_pkg::ST_RUN && selWrite) begin
			delayQ   <= power_down_pkg::ENTRY_DELAY;
			pendSelQ <= newSel;
		end else if (stateQ == power_down_pkg::ST_ARM) begin
			delayQ <= delayQ - 4'h1;
		end
	end

	// outputs
	always_ff @(posedge clock) begin
		if (srst) begin
			serviceRequest <= 1'b0;
			resumeAtSleep  <= 1'b0;
		end else begin
			serviceRequest <= (stateD == power_down_pkg::ST_SERVICE);
			// resume follows the service pulse, never coincides with it
			resumeAtSleep  <= (stateD == power_down_pkg::ST_RUN &&
			                   (stateQ == power_down_pkg::ST_LIGHT ||
			                    stateQ == power_down_pkg::ST_SERVICE));
		end
	end

	wire lightOn = (stateQ == power_down_pkg::ST_LIGHT);
	wire outStop = (stateQ == power_down_pkg::ST_PLL_OUT);
	wire inStop  = (stateQ == power_down_pkg::ST_PLL_IN);
	assign cpuClockEnable  = !(lightOn || frozen || stateQ == power_down_pkg::ST_RELOCK);
	assign dmaClockEnable  = !(frozen || stateQ == power_down_pkg::ST_RELOCK);
	assign pllOutputEnable = !(outStop || inStop);
	// other external clocks are never touched here
	assign refClockGate    = inStop;
	assign thirdClockGate  = frozen;
	// async peripherals outside this block may still toggle while frozen
	assign ioFreeze        = frozen;
	assign pllLocked       = !inStop && stateQ != power_down_pkg::ST_RELOCK;
endmodule

//--- sim/power_down_mode_logic_monitor.sv
// port assertions for the power-down controller
`timescale 1ns/1ps
module power_down_mode_logic_monitor (
	// clock, reset and bus
	input wire logic        clock, srst, read, write, waitrequest,
	input wire logic [3:0]  address, byteenable,
	input wire logic [31:0] writedata,
	// interrupt and clock control
	input wire logic        irqPending, irqEnabled, serviceRequest, resumeAtSleep,
	input wire logic        cpuClockEnable, dmaClockEnable, pllOutputEnable,
	input wire logic        refClockGate, thirdClockGate, ioFreeze, pllLocked
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// accepted light-sleep write issued from the running state
	wire lightWr = write && !waitrequest && address == 4'h0 && byteenable[1]
		&& writedata[15:10] == 6'h09 && cpuClockEnable && !irqPending;
	sequence sAwake9;
		cpuClockEnable [*8] ##1 cpuClockEnable;
	endsequence
	a_read_first_wait: assert property ($rose(read) |-> waitrequest) else $error("read not stalled");
	a_read_one_wait: assert property (read && waitrequest |=> !waitrequest) else $error("read stall too long");
	a_write_no_wait: assert property (write && !ioFreeze |-> !waitrequest) else $error("write stalled");
	a_entry_delay: assert property (lightWr |=> sAwake9 ##1 !cpuClockEnable) else $error("entry delay wrong");
	a_light_dma: assert property (!cpuClockEnable && pllLocked && !ioFreeze |-> dmaClockEnable)
		else $error("dma stopped in light sleep");
	a_light_holds: assert property (!cpuClockEnable && dmaClockEnable && !irqPending |=> !cpuClockEnable)
		else $error("woke without interrupt");
	a_pulse_single: assert property (resumeAtSleep |-> !serviceRequest
		##1 !(serviceRequest || resumeAtSleep)) else $error("wake pulse wrong");
	a_service_first: assert property (serviceRequest |=> resumeAtSleep && !serviceRequest)
		else $error("no resume after service");
	a_deep_stays: assert property (ioFreeze |=> ioFreeze && !pllOutputEnable) else $error("left deep sleep");
	a_deep_halts: assert property (ioFreeze |-> !cpuClockEnable && !dmaClockEnable) else $error("clock in deep");
	a_run_ungated: assert property (cpuClockEnable && pllLocked |-> !refClockGate && !thirdClockGate)
		else $error("gate while running");
	a_relock_hold: assert property (!pllLocked |-> !cpuClockEnable && !dmaClockEnable) else $error("ran unlocked");
endmodule
bind power_down_mode_logic power_down_mode_logic_monitor i_power_down_mode_logic_monitor (.*);

//--- sim/power_down_mode_logic_test.sv
// self-checking bench for the power-down controller
`timescale 1ns/1ps
module power_down_mode_logic_test;
	logic        clock = 0, srst = 1, read = 0, write = 0, irqPending = 0, irqEnabled = 0;
	logic [3:0]  address = 4'h0, byteenable = 4'hF;
	logic [31:0] writedata = 32'h0000_0000, readdata;
	logic        waitrequest, serviceRequest, resumeAtSleep, cpuClockEnable, dmaClockEnable;
	logic        pllOutputEnable, refClockGate, thirdClockGate, ioFreeze, pllLocked;
	int          badCount = 0, numChecks = 0;
	// short relock keeps the deep-wake scenario brief
	power_down_mode_logic #(.RELOCK(16'h0008)) i_power_down_mode_logic (.*);
	initial forever #2.5 clock = ~clock;
	task automatic chk(input logic ok, input string msg);
		numChecks++;
		if (ok !== 1'b1) begin
			badCount++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	// one avalon transfer; a read compares against d
	task automatic xfer(input logic rd, input logic [3:0] a, input logic [31:0] d);
		int n = 0;
		logic done = 1'b0;
		logic [31:0] got = 32'h0000_0000;
		read <= rd;
		write <= !rd;
		address <= a;
		writedata <= d;
		// sample the answer settled before the edge that takes it
		do begin
			#1;
			done = (waitrequest === 1'b0);
			got = readdata;
			@(posedge clock);
			n++;
		end while (!done && n < 50);
		chk(done && (!rd || got === d), "bus transfer");
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic waitOn(ref logic s, input logic v, input int lim);
		#1;
		for (int i = 0; i < lim && s !== v; i++) begin
			@(posedge clock);
			#1;
		end
		chk(s === v, "awaited level missing");
		@(posedge clock);
	endtask
	task automatic lightEnabled();
		xfer(0, 4'h0, 32'h0000_2403);
		waitOn(cpuClockEnable, 0, 12);
		irqPending <= 1'b1;
		repeat (4) @(posedge clock);
		chk(cpuClockEnable === 1'b0 && dmaClockEnable === 1'b1, "left sleep early");
		irqEnabled <= 1'b1;
		waitOn(serviceRequest, 1, 6);
		waitOn(resumeAtSleep, 1, 3);
		irqPending <= 1'b0;
		irqEnabled <= 1'b0;
	endtask
	task automatic lightNoEnable();
		xfer(0, 4'h0, 32'h0000_2401);
		waitOn(cpuClockEnable, 0, 12);
		irqPending <= 1'b1;
		irqEnabled <= 1'b1;
		waitOn(resumeAtSleep, 1, 6);
		irqPending <= 1'b0;
		irqEnabled <= 1'b0;
	endtask
	task automatic lightAny();
		xfer(0, 4'h0, 32'h0000_4400);
		waitOn(cpuClockEnable, 0, 12);
		irqPending <= 1'b1;
		waitOn(resumeAtSleep, 1, 6);
		irqPending <= 1'b0;
	endtask
	// a code that must leave the core running
	task automatic noSleep(input logic [31:0] d);
		xfer(0, 4'h0, d);
		repeat (12) @(posedge clock);
		chk(cpuClockEnable === 1'b1 && ioFreeze === 1'b0, "clock stopped");
		xfer(1, 4'h0, d);
	endtask
	task automatic deep(input logic [31:0] d, input logic lockNow);
		xfer(0, 4'h4, 32'h0000_0001);
		xfer(0, 4'h0, d);
		waitOn(ioFreeze, 1, 12);
		irqPending <= 1'b1;
		irqEnabled <= 1'b1;
		repeat (6) @(posedge clock);
		chk(ioFreeze === 1'b1 && cpuClockEnable === 1'b0, "irq ended deep sleep");
		irqPending <= 1'b0;
		irqEnabled <= 1'b0;
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		chk(pllLocked === lockNow && ioFreeze === 1'b0, "state after reset");
		waitOn(pllLocked, 1, 12);
	endtask
	task automatic printVerdict();
		$display("checks %0d mismatches %0d", numChecks, badCount);
		if (badCount == 0 && numChecks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		xfer(1, 4'h0, 32'h0000_0000);
		xfer(1, 4'h2, 32'h0000_0000);
		lightEnabled();
		lightNoEnable();
		lightAny();
		noSleep(32'h0000_0C00);
		noSleep(32'h0000_6800);
		deep(32'h0000_6800, 1'b1);
		deep(32'h0000_7000, 1'b0);
		printVerdict();
	end
	initial begin
		#20000;
		badCount++;
		printVerdict();
	end
endmodule
